// *** acc_edge_if.sv ***
`default_nettype none
interface acc_edge_if;
   logic level;
   logic rise;
   logic fall;
   modport src (output level, output rise, output fall);
   modport dst (input level, input rise, input fall);
endinterface
`default_nettype wire

// *** acc_map.svh ***
`ifndef ACC_MAP_SVH
`define ACC_MAP_SVH
// data-space offsets
`define ACC_OFF_CTRL 8'h50
`define ACC_IO_DELTA 8'h20
`define ACC_OFF_CONV_B 8'h7b
`define ACC_OFF_PIN_DIS 8'h7f
// comparator_control_status fields
`define ACC_BIT_DISABLE 7
`define ACC_BIT_BANDGAP 6
`define ACC_BIT_RESULT 5
`define ACC_BIT_FLAG 4
`define ACC_BIT_IRQ_EN 3
`define ACC_BIT_CAPTURE 2
`define ACC_BIT_MODE_HI 1
`define ACC_BIT_MODE_LO 0
// converter_control_status_b fields
`define ACC_BIT_MUX_EN 6
`define ACC_TRIG_HI 2
`define ACC_TRIG_LO 0
// comparator_pin_input_disable fields
`define ACC_BIT_NEG_DIS 1
`define ACC_BIT_POS_DIS 0
// reset values
`define ACC_RST_CONV_B 8'h00
`define ACC_RST_PIN_DIS 8'h00
`define ACC_RST_CTRL 8'h00
`endif

// *** acc_pkg.sv ***
`default_nettype none
package acc_pkg;
   typedef enum logic [1:0] {
      acc_mode_toggle = 2'b00,
      acc_mode_reserved = 2'b01,
      acc_mode_fall = 2'b10,
      acc_mode_rise = 2'b11
   } acc_mode_t;
   typedef enum logic [2:0] {
      acc_trig_free = 3'b000,
      acc_trig_comparator = 3'b001,
      acc_trig_ext_irq0 = 3'b010,
      acc_trig_t0_cmp_a = 3'b011,
      acc_trig_t0_ovf = 3'b100,
      acc_trig_t1_cmp_b = 3'b101,
      acc_trig_t1_ovf = 3'b110,
      acc_trig_t1_capture = 3'b111
   } acc_trig_t;
endpackage
`default_nettype wire

// *** acc_sync_edge.sv ***
`default_nettype none
// two-stage synchronizer followed by a previous-value register for edges
module acc_sync_edge (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic async_in,
   acc_edge_if.src edge_out
);
   logic meta;
   logic sync;
   logic prev;
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         meta <= 1'b0;
         sync <= 1'b0;
         prev <= 1'b0;
      end else begin
         meta <= async_in;
         sync <= meta;
         prev <= sync;
      end
   end
   assign edge_out.level = sync;
   assign edge_out.rise = sync & ~prev;
   assign edge_out.fall = ~sync & prev;
endmodule
`default_nettype wire

// *** acc_top.sv ***
`include "acc_map.svh"
`default_nettype none
module acc_top #(
   parameter int CHANNELS = 8
) (
   input wire logic clock,
   input wire logic sys_rst,
   // cpu register port
   input wire logic [7:0] addr,
   input wire logic io_space,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wr_data,
   output logic [7:0] rd_data,
   output logic hit,
   // analog comparator core
   input wire logic compare_raw,
   output logic comparator_power_down,
   output logic positive_use_bandgap,
   output logic negative_use_channel,
   output logic [2:0] negative_channel,
   // converter side
   input wire logic converter_enable_bit,
   input wire logic auto_trigger_enable_bit,
   input wire logic [2:0] channel_select_bits,
   input wire logic [7:0] trigger_flags,
   output logic converter_trigger,
   output logic [2:0] auto_trigger_source_field,
   // interrupt side
   input wire logic global_irq_enable,
   input wire logic irq_vector_taken,
   output logic compare_irq,
   // timer1 capture front end
   output logic capture_input,
   output logic capture_route_enable,
   // digital input buffers of the two comparator pins
   input wire logic positive_pin_digital,
   input wire logic negative_pin_digital,
   output logic positive_pin_read,
   output logic negative_pin_read,
   output logic positive_pin_buffer_off,
   output logic negative_pin_buffer_off
);
   logic comparator_disable_bit;
   logic bandgap_select_bit;
   logic compare_event_flag;
   logic compare_irq_enable;
   logic [1:0] edge_mode;
   logic mux_negative_select_enable;
   logic [2:0] trig_sel;
   logic positive_pin_input_disable;
   logic negative_pin_input_disable;
   logic trig_prev;
   logic pos_meta, pos_sync, neg_meta, neg_sync;

   acc_edge_if cmp_edge ();

   // the analog core makes compare_raw high when positive exceeds negative
   acc_sync_edge u_sync (
      .clock(clock),
      .sys_rst(sys_rst),
      .async_in(compare_raw),
      .edge_out(cmp_edge.src)
   );

   // address decode: data space, or i/o space with offset reduced for the control register only
   wire [7:0] eff_addr = io_space ? 8'(addr + `ACC_IO_DELTA) : addr;
   wire sel_ctrl = (eff_addr == `ACC_OFF_CTRL);
   wire sel_conv_b = ~io_space & (eff_addr == `ACC_OFF_CONV_B);
   wire sel_pin_dis = ~io_space & (eff_addr == `ACC_OFF_PIN_DIS);
   wire wr_ctrl = wr_en & sel_ctrl;
   wire wr_conv_b = wr_en & sel_conv_b;
   wire wr_pin_dis = wr_en & sel_pin_dis;

   // negative input selection
   wire use_channel = mux_negative_select_enable & ~converter_enable_bit;
   assign negative_use_channel = use_channel;
   assign negative_channel = use_channel ? channel_select_bits : 3'h0;
   assign positive_use_bandgap = bandgap_select_bit;
   assign comparator_power_down = comparator_disable_bit;

   // event detection by edge mode
   wire ev_toggle = cmp_edge.rise | cmp_edge.fall;
   logic mode_event;
   always_comb begin
      case (acc_pkg::acc_mode_t'(edge_mode))
         acc_pkg::acc_mode_toggle: mode_event = ev_toggle;
         acc_pkg::acc_mode_fall: mode_event = cmp_edge.fall;
         acc_pkg::acc_mode_rise: mode_event = cmp_edge.rise;
         acc_pkg::acc_mode_reserved: mode_event = 1'b0;
         default: mode_event = 1'b0;
      endcase
   end
   wire flag_clear = irq_vector_taken | (wr_ctrl & wr_data[`ACC_BIT_FLAG]);

   assign compare_irq = compare_event_flag & compare_irq_enable & global_irq_enable;

   // capture routing
   logic capture_route_q;
   assign capture_route_enable = capture_route_q;
   assign capture_input = capture_route_q & cmp_edge.level;

   // auto-trigger source selection; comparator source is the event flag
   logic sel_flag;
   always_comb begin
      case (acc_pkg::acc_trig_t'(trig_sel))
         acc_pkg::acc_trig_free: sel_flag = 1'b0;
         acc_pkg::acc_trig_comparator: sel_flag = compare_event_flag;
         acc_pkg::acc_trig_ext_irq0: sel_flag = trigger_flags[2];
         acc_pkg::acc_trig_t0_cmp_a: sel_flag = trigger_flags[3];
         acc_pkg::acc_trig_t0_ovf: sel_flag = trigger_flags[4];
         acc_pkg::acc_trig_t1_cmp_b: sel_flag = trigger_flags[5];
         acc_pkg::acc_trig_t1_ovf: sel_flag = trigger_flags[6];
         acc_pkg::acc_trig_t1_capture: sel_flag = trigger_flags[7];
         default: sel_flag = 1'b0;
      endcase
   end
   wire trig_gated = auto_trigger_enable_bit & sel_flag;
   // reselection to a set source shows as an edge here too
   assign converter_trigger = trig_gated & ~trig_prev & converter_enable_bit;
   assign auto_trigger_source_field = trig_sel;

   // digital input disable
   assign positive_pin_buffer_off = positive_pin_input_disable;
   assign negative_pin_buffer_off = negative_pin_input_disable;
   assign positive_pin_read = pos_sync & ~positive_pin_input_disable;
   assign negative_pin_read = neg_sync & ~negative_pin_input_disable;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         pos_meta <= 1'b0;
         pos_sync <= 1'b0;
         neg_meta <= 1'b0;
         neg_sync <= 1'b0;
      end else begin
         pos_meta <= positive_pin_digital;
         pos_sync <= pos_meta;
         neg_meta <= negative_pin_digital;
         neg_sync <= neg_meta;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         comparator_disable_bit <= 1'b0;
         bandgap_select_bit <= 1'b0;
         compare_irq_enable <= 1'b0;
         capture_route_q <= 1'b0;
         edge_mode <= 2'h0;
      end else if (wr_ctrl) begin
         comparator_disable_bit <= wr_data[`ACC_BIT_DISABLE];
         bandgap_select_bit <= wr_data[`ACC_BIT_BANDGAP];
         compare_irq_enable <= wr_data[`ACC_BIT_IRQ_EN];
         capture_route_q <= wr_data[`ACC_BIT_CAPTURE];
         edge_mode <= wr_data[`ACC_BIT_MODE_HI:`ACC_BIT_MODE_LO];
      end
   end

   // set wins over a clear in the same cycle
   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         compare_event_flag <= 1'b0;
      end else if (mode_event) begin
         compare_event_flag <= 1'b1;
      end else if (flag_clear) begin
         compare_event_flag <= 1'b0;
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         mux_negative_select_enable <= 1'b0;
         trig_sel <= 3'h0;
      end else if (wr_conv_b) begin
         mux_negative_select_enable <= wr_data[`ACC_BIT_MUX_EN];
         trig_sel <= wr_data[`ACC_TRIG_HI:`ACC_TRIG_LO];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         positive_pin_input_disable <= 1'b0;
         negative_pin_input_disable <= 1'b0;
      end else if (wr_pin_dis) begin
         positive_pin_input_disable <= wr_data[`ACC_BIT_POS_DIS];
         negative_pin_input_disable <= wr_data[`ACC_BIT_NEG_DIS];
      end
   end

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         trig_prev <= 1'b0;
      end else begin
         trig_prev <= trig_gated;
      end
   end

   // read mux
   wire [7:0] ctrl_val = {comparator_disable_bit, bandgap_select_bit, cmp_edge.level,
      compare_event_flag, compare_irq_enable, capture_route_q, edge_mode};
   wire [7:0] conv_b_val = {1'b0, mux_negative_select_enable, 3'h0, trig_sel};
   wire [7:0] pin_dis_val = {6'h00, negative_pin_input_disable, positive_pin_input_disable};
   wire [7:0] rd_mux = sel_ctrl ? ctrl_val : sel_conv_b ? conv_b_val :
      sel_pin_dis ? pin_dis_val : 8'h00;

   always_ff @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         rd_data <= 8'h00;
      end else if (rd_en) begin
         rd_data <= rd_mux;
      end
   end
   assign hit = sel_ctrl | sel_conv_b | sel_pin_dis;
endmodule
`default_nettype wire

// *** acc_top_sva.sv ***
`default_nettype none
module acc_chk (
   input wire logic clock,
   input wire logic sys_rst,
   input wire logic [7:0] addr,
   input wire logic io_space,
   input wire logic wr_en,
   input wire logic rd_en,
   input wire logic [7:0] wr_data,
   input wire logic [7:0] rd_data,
   input wire logic hit,
   input wire logic compare_raw,
   input wire logic comparator_power_down,
   input wire logic negative_use_channel,
   input wire logic [2:0] negative_channel,
   input wire logic converter_enable_bit,
   input wire logic [2:0] channel_select_bits,
   input wire logic global_irq_enable,
   input wire logic compare_irq,
   input wire logic capture_input,
   input wire logic capture_route_enable,
   input wire logic positive_pin_read,
   input wire logic positive_pin_buffer_off
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge clock); endclocking
   default disable iff (sys_rst);
   chk_mux_blocked: assert property (
      converter_enable_bit |-> !negative_use_channel) else $error("mux used, converter on");
   chk_mux_channel: assert property (
      negative_use_channel |-> negative_channel == channel_select_bits)
      else $error("wrong negative channel");
   chk_io_alias: assert property (io_space && addr == 8'h30 |-> hit)
      else $error("io alias missed");
   chk_refused_read: assert property (rd_en && !hit |=> rd_data == 8'h00)
      else $error("unmapped read not zero");
   chk_power_write: assert property (
      wr_en && (io_space ? addr == 8'h30 : addr == 8'h50)
      |=> comparator_power_down == $past(wr_data[7])) else $error("power bit not written");
   chk_irq_gate: assert property (compare_irq |-> global_irq_enable)
      else $error("irq without global enable");
   chk_capture_gate: assert property (capture_input |-> capture_route_enable)
      else $error("capture fed while route off");
   chk_pin_forced: assert property (positive_pin_buffer_off |-> !positive_pin_read)
      else $error("disabled pin reads one");
   chk_sync_delay: assert property (
      capture_route_enable && $rose(capture_input) |-> $past(compare_raw, 2))
      else $error("result not two edges behind");
   cover property (compare_irq);
   cover property (negative_use_channel);
   cover property ($rose(capture_input));
endmodule
bind acc_top acc_chk u_chk (.clock, .sys_rst, .addr, .io_space, .wr_en, .rd_en, .wr_data,
   .rd_data, .hit, .compare_raw, .comparator_power_down, .negative_use_channel,
   .negative_channel, .converter_enable_bit, .channel_select_bits, .global_irq_enable,
   .compare_irq, .capture_input, .capture_route_enable, .positive_pin_read,
   .positive_pin_buffer_off);
`default_nettype wire

// *** testbench.sv ***
`default_nettype none
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic clock, sys_rst, io_space, wr_en, rd_en, compare_raw, hit, converter_trigger;
   logic [7:0] addr, wr_data, rd_data, trigger_flags;
   logic [2:0] channel_select_bits, negative_channel, auto_trigger_source_field;
   logic comparator_power_down, positive_use_bandgap, negative_use_channel, compare_irq;
   logic converter_enable_bit, auto_trigger_enable_bit, global_irq_enable, irq_vector_taken;
   logic capture_input, capture_route_enable, positive_pin_digital, negative_pin_digital;
   logic positive_pin_read, negative_pin_read, positive_pin_buffer_off, negative_pin_buffer_off;
   int failures = 0;
   int cmp_count = 0;
   acc_top DUT (.clock, .sys_rst, .addr, .io_space, .wr_en, .rd_en, .wr_data, .rd_data, .hit,
      .compare_raw, .comparator_power_down, .positive_use_bandgap, .negative_use_channel,
      .negative_channel, .converter_enable_bit, .auto_trigger_enable_bit, .channel_select_bits,
      .trigger_flags, .converter_trigger, .auto_trigger_source_field, .global_irq_enable,
      .irq_vector_taken, .compare_irq, .capture_input, .capture_route_enable,
      .positive_pin_digital, .negative_pin_digital, .positive_pin_read, .negative_pin_read,
      .positive_pin_buffer_off, .negative_pin_buffer_off);
   initial begin
      clock = 1'b0;
      forever #20 clock = ~clock;
   end
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         failures++;
         $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic complete_run();
      if (failures == 0 && cmp_count > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task automatic wr(input logic [7:0] a, input logic io, input logic [7:0] d);
      @(posedge clock);
      addr <= a;
      io_space <= io;
      wr_data <= d;
      wr_en <= 1'b1;
      @(posedge clock);
      wr_en <= 1'b0;
   endtask
   task automatic rd(input logic [7:0] a, input logic io, input logic [7:0] exp);
      @(posedge clock);
      addr <= a;
      io_space <= io;
      rd_en <= 1'b1;
      @(posedge clock);
      rd_en <= 1'b0;
      #1 chk(rd_data, exp);
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   initial begin
      #400000;
      failures++;
      complete_run();
   end
   initial begin
      {addr, wr_data, trigger_flags, channel_select_bits} = '0;
      {io_space, wr_en, rd_en, compare_raw, converter_enable_bit} = '0;
      {auto_trigger_enable_bit, global_irq_enable, irq_vector_taken} = '0;
      {positive_pin_digital, negative_pin_digital} = '0;
      sys_rst = 1'b1;
      repeat (20) @(posedge clock);
      sys_rst <= 1'b0;
      rd(8'h50, 1'b0, 8'h00);
      rd(8'h7b, 1'b0, 8'h00);
      rd(8'h7f, 1'b0, 8'h00);
      rd(8'h51, 1'b0, 8'h00);
      chk(hit, 8'h00);
      rd(8'h7b, 1'b1, 8'h00);
      chk(hit, 8'h00);
      wr(8'h7b, 1'b0, 8'hff);
      rd(8'h7b, 1'b0, 8'h47);
      chk(auto_trigger_source_field, 8'h07);
      @(posedge clock) positive_pin_digital <= 1'b1;
      negative_pin_digital <= 1'b1;
      wr(8'h7f, 1'b0, 8'hff);
      rd(8'h7f, 1'b0, 8'h03);
      chk({positive_pin_read, negative_pin_read, positive_pin_buffer_off,
         negative_pin_buffer_off}, 8'h03);
      wr(8'h7f, 1'b0, 8'h00);
      cyc(3);
      chk({positive_pin_read, negative_pin_read}, 8'h03);
      wr(8'h7b, 1'b0, 8'h40);
      for (int i = 0; i < 8; i++) begin
         @(posedge clock) channel_select_bits <= 3'(i);
         #1 chk({negative_use_channel, negative_channel}, 8'h08 | 8'(i));
      end
      @(posedge clock) converter_enable_bit <= 1'b1;
      #1 chk(negative_use_channel, 8'h00);
      wr(8'h30, 1'b1, 8'hc0);
      #1 chk({comparator_power_down, positive_use_bandgap}, 8'h03);
      chk(hit, 8'h01);
      rd(8'h50, 1'b0, 8'hc0);
      wr(8'h30, 1'b1, 8'h00);
      #1 chk({comparator_power_down, positive_use_bandgap}, 8'h00);
      @(posedge clock) global_irq_enable <= 1'b1;
      for (int m = 0; m < 4; m++) begin
         wr(8'h50, 1'b0, 8'h10 | 8'(m));
         wr(8'h50, 1'b0, 8'h1c | 8'(m));
         @(posedge clock) compare_raw <= 1'b1;
         cyc(4);
         chk(compare_irq, 8'(m == 0 || m == 3));
         chk(capture_input, 8'h01);
         chk(capture_route_enable, 8'h01);
         rd(8'h50, 1'b0, 8'h2c | (m == 0 || m == 3 ? 8'h10 : 8'h00) | 8'(m));
         wr(8'h50, 1'b0, 8'h1c | 8'(m));
         #1 chk(compare_irq, 8'h00);
         @(posedge clock) compare_raw <= 1'b0;
         cyc(4);
         chk(compare_irq, 8'(m == 0 || m == 2));
         @(posedge clock) irq_vector_taken <= 1'b1;
         @(posedge clock) irq_vector_taken <= 1'b0;
         #1 chk(compare_irq, 8'h00);
         wr(8'h50, 1'b0, 8'h14 | 8'(m));
      end
      wr(8'h50, 1'b0, 8'h03);
      @(posedge clock) compare_raw <= 1'b1;
      cyc(4);
      chk({capture_route_enable, capture_input, compare_irq}, 8'h00);
      rd(8'h50, 1'b0, 8'h33);
      @(posedge clock) auto_trigger_enable_bit <= 1'b1;
      wr(8'h7b, 1'b0, 8'h01);
      #1 chk(converter_trigger, 8'h01);
      for (int c = 2; c < 8; c++) begin
         wr(8'h7b, 1'b0, 8'(c));
         @(posedge clock) trigger_flags <= 8'h01 << c;
         #1 chk(converter_trigger, 8'h01);
         @(posedge clock) trigger_flags <= 8'h00;
         #1 chk(converter_trigger, 8'h00);
      end
      @(posedge clock) auto_trigger_enable_bit <= 1'b0;
      trigger_flags <= 8'h81;
      #1 chk(converter_trigger, 8'h00);
      @(posedge clock) auto_trigger_enable_bit <= 1'b1;
      wr(8'h7b, 1'b0, 8'h02);
      wr(8'h7b, 1'b0, 8'h07);
      #1 chk(converter_trigger, 8'h01);
      wr(8'h7b, 1'b0, 8'h02);
      wr(8'h7b, 1'b0, 8'h00);
      #1 chk(converter_trigger, 8'h00);
      complete_run();
   end
endmodule
`default_nettype wire
